// ==== test/dag_far_model.sv ====
// memory bus side: counts and records issued addresses
`timescale 1ns/1ps
module dag_far_model (
   input wire clk,
   input wire addr_valid,
   input wire [31:0] addr_out,
   output reg [31:0] last_addr,
   output reg [15:0] accesses
);
   initial
   begin
      accesses = 16'h0;
      last_addr = 32'h0;
   end
   // a modify or bitrev must never reach memory
   always @(posedge clk)
      if (addr_valid)
      begin
         accesses <= accesses + 16'h1;
         last_addr <= addr_out;
      end
endmodule

// ==== test/dag_unit_chk.sv ====
// port assertions for the data address generator
`timescale 1ns/1ps
`include "dag_map.vh"
module dag_unit_chk (
   input wire clk,
   input wire reset_n,
   input wire simd_enable,
   input wire op_valid,
   input wire [2:0] op_code,
   input wire op_unit,
   input wire [2:0] op_index,
   input wire [1:0] rd_fmt,
   input wire addr_valid,
   input wire addr_unit,
   input wire [63:0] rd_bus_primary,
   input wire [63:0] rd_bus_secondary,
   input wire wrap_irq_index_unit_a,
   input wire wrap_irq_index_unit_b
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence access_op_s;
      op_valid && (op_code == `DAG_OP_POST || op_code == `DAG_OP_PRE);
   endsequence
   sequence quiet_op_s;
      op_valid && (op_code == `DAG_OP_MODIFY || op_code == `DAG_OP_BITREV);
   endsequence
   // irq traces back two cycles to a wrapping op on index seven
   sequence irq_src_s(u);
      $past(op_valid, 2) && $past(op_unit, 2) == u && $past(op_index, 2) == 3'h7
         && $past(op_code, 2) != `DAG_OP_PRE;
   endsequence
   addr_issue_a: assert property (access_op_s |=> addr_valid && addr_unit == $past(op_unit))
      else $error("no address after access op");
   no_access_a: assert property (quiet_op_s |=> !addr_valid)
      else $error("address issued by modify op");
   idle_addr_a: assert property (!op_valid |=> !addr_valid)
      else $error("address issued with no op");
   irq_unit_a_a: assert property (wrap_irq_index_unit_a |-> irq_src_s(1'b0))
      else $error("unit a irq without cause");
   irq_unit_b_a: assert property (wrap_irq_index_unit_b |-> irq_src_s(1'b1))
      else $error("unit b irq without cause");
   // secondary bus follows the mode seen at the edge that loads it
   simd_copy_a: assert property ($past(simd_enable) |-> rd_bus_secondary == rd_bus_primary)
      else $error("secondary bus differs in simd");
   sisd_zero_a: assert property (!$past(simd_enable) |-> rd_bus_secondary == 64'h0)
      else $error("secondary bus busy in sisd");
   normal_low_a: assert property ($past(rd_fmt, 2) == `DAG_FMT_NORMAL
      |-> rd_bus_primary[63:32] == 32'h0)
      else $error("normal word above bit 31");
   ext_mid_a: assert property ($past(rd_fmt, 2) == `DAG_FMT_EXT
      |-> rd_bus_primary[63:40] == 24'h0 && rd_bus_primary[7:0] == 8'h0)
      else $error("extended word outside bits 39-8");
endmodule
bind dag_unit dag_unit_chk u_dag_unit_chk (.*);

// ==== test/dag_unit_test.sv ====
// self-checking bench for the data address generator
`timescale 1ns/1ps
`include "dag_map.vh"
module dag_unit_test;
   reg clk, reset_n, circ_buf_enable, simd_enable, op_valid, op_unit, op_use_imm, op_wide;
   reg [2:0] op_code, op_index, op_modify, wr_reg, rd_reg;
   reg [31:0] op_imm, a_seen;
   reg wr_valid, wr_unit, wr_from_primary, wr_from_secondary, rd_unit;
   reg [1:0] wr_class, wr_fmt, rd_class, rd_fmt, irq_seen;
   reg [63:0] wr_bus_primary, wr_bus_secondary, v;
   wire addr_valid, addr_unit, wrap_irq_index_unit_a, wrap_irq_index_unit_b;
   wire [31:0] addr_out, last_addr;
   wire [63:0] rd_bus_primary, rd_bus_secondary;
   wire [15:0] accesses;
   integer mismatches, tests_run;
   dag_unit u_dag_unit (.clk, .reset_n, .circ_buf_enable, .simd_enable, .op_valid, .op_code,
      .op_unit, .op_index, .op_use_imm, .op_modify, .op_imm, .op_wide, .wr_valid, .wr_unit,
      .wr_class, .wr_reg, .wr_fmt, .wr_from_primary, .wr_from_secondary, .wr_bus_primary,
      .wr_bus_secondary, .rd_unit, .rd_class, .rd_reg, .rd_fmt, .addr_valid, .addr_unit,
      .addr_out, .rd_bus_primary, .rd_bus_secondary, .wrap_irq_index_unit_a,
      .wrap_irq_index_unit_b);
   dag_far_model u_dag_far_model (.clk, .addr_valid, .addr_out, .last_addr, .accesses);
   task tick;
      begin
         @(posedge clk);
         #1;
      end
   endtask
   task check(input [8*8:1] what, input [63:0] exp, input [63:0] got);
      begin
         tests_run = tests_run + 1;
         if (got !== exp)
         begin
            mismatches = mismatches + 1;
            $display("wrong value %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task wreg(input u, input [1:0] c, input [2:0] r, input [1:0] f, input [63:0] d);
      begin
         {wr_unit, wr_class, wr_reg, wr_fmt, wr_bus_primary, wr_valid} = {u, c, r, f, d, 1'b1};
         tick;
         wr_valid = 1'b0;
         // idle edge so the next write strobe is a fresh pulse
         tick;
      end
   endtask
   task rdreg(input u, input [1:0] c, input [2:0] r, input [1:0] f);
      begin
         {rd_unit, rd_class, rd_reg, rd_fmt} = {u, c, r, f};
         tick;
         tick;
         v = rd_bus_primary;
      end
   endtask
   // one op, then its address one cycle later and the irq pair two cycles later
   task op(input [2:0] k, input u, input [2:0] i, input ui, input [2:0] m, input [31:0] d);
      begin
         {op_code, op_unit, op_index, op_use_imm, op_modify, op_imm} = {k, u, i, ui, m, d};
         op_valid = 1'b1;
         tick;
         op_valid = 1'b0;
         a_seen = addr_out;
         tick;
         irq_seen = {wrap_irq_index_unit_b, wrap_irq_index_unit_a};
      end
   endtask
   task circ_pos_wrap;
      begin
         circ_buf_enable = 1'b1;
         wreg(0, `DAG_CLS_B, 7, `DAG_FMT_NORMAL, 8'h64);
         wreg(0, `DAG_CLS_L, 7, `DAG_FMT_NORMAL, 8'h0a);
         wreg(0, `DAG_CLS_M, 1, `DAG_FMT_NORMAL, 8'h04);
         rdreg(0, `DAG_CLS_I, 7, `DAG_FMT_NORMAL); check("index", 8'h64, v);
         op(`DAG_OP_POST, 0, 7, 0, 1, 0); check("addr", 8'h64, a_seen);
         op(`DAG_OP_POST, 0, 7, 0, 1, 0); check("addr", 8'h68, a_seen);
         check("irq", 2'b00, irq_seen);
         op(`DAG_OP_POST, 0, 7, 0, 1, 0); check("addr", 8'h6c, a_seen);
         check("irq", 2'b01, irq_seen);
         rdreg(0, `DAG_CLS_I, 7, `DAG_FMT_NORMAL); check("index", 8'h66, v);
      end
   endtask
   task circ_neg_imm;
      begin
         wreg(1, `DAG_CLS_B, 7, `DAG_FMT_NORMAL, 8'hc8);
         wreg(1, `DAG_CLS_L, 7, `DAG_FMT_NORMAL, 8'h08);
         op(`DAG_OP_POST, 1, 7, 1, 0, 32'hffff_fffd); check("irq", 2'b10, irq_seen);
         rdreg(1, `DAG_CLS_I, 7, `DAG_FMT_NORMAL); check("index", 8'hcd, v);
      end
   endtask
   task circ_off_modify;
      begin
         circ_buf_enable = 1'b0;
         wreg(0, `DAG_CLS_B, 2, `DAG_FMT_NORMAL, 8'h32);
         wreg(0, `DAG_CLS_L, 2, `DAG_FMT_NORMAL, 8'h04);
         op(`DAG_OP_POST, 0, 2, 1, 0, 8'h0a); check("addr", 8'h32, a_seen);
         rdreg(0, `DAG_CLS_I, 2, `DAG_FMT_NORMAL); check("index", 8'h3c, v);
         wreg(0, `DAG_CLS_I, 2, `DAG_FMT_NORMAL, 8'h34);
         op(`DAG_OP_MODIFY, 0, 2, 1, 0, 8'h03);
         rdreg(0, `DAG_CLS_I, 2, `DAG_FMT_NORMAL); check("index", 8'h33, v);
         op(`DAG_OP_PRE, 0, 2, 1, 0, 8'h03); check("addr", 8'h36, a_seen);
         rdreg(0, `DAG_CLS_I, 2, `DAG_FMT_NORMAL); check("index", 8'h33, v);
         rdreg(0, `DAG_CLS_B, 2, `DAG_FMT_NORMAL); check("base", 8'h32, v);
      end
   endtask
   task zero_len_bitrev;
      begin
         circ_buf_enable = 1'b1;
         wreg(0, `DAG_CLS_B, 3, `DAG_FMT_NORMAL, 8'h10);
         op(`DAG_OP_POST, 0, 3, 1, 0, 8'h20);
         rdreg(0, `DAG_CLS_I, 3, `DAG_FMT_NORMAL); check("index", 8'h30, v);
         op(`DAG_OP_BITREV, 0, 3, 1, 0, 8'h01);
         rdreg(0, `DAG_CLS_I, 3, `DAG_FMT_NORMAL); check("bitrev", 32'h8c00_0000, v);
      end
   endtask
   task bus_formats;
      begin
         wreg(0, `DAG_CLS_M, 5, `DAG_FMT_EXT, 40'hab_cdef_1200);
         rdreg(0, `DAG_CLS_M, 5, `DAG_FMT_NORMAL); check("normal", 32'habcd_ef12, v);
         rdreg(0, `DAG_CLS_M, 5, `DAG_FMT_EXT); check("ext", 40'hab_cdef_1200, v);
         wreg(1, `DAG_CLS_M, 6, `DAG_FMT_LONG, 64'h1111_2222_3333_4444);
         rdreg(1, `DAG_CLS_M, 7, `DAG_FMT_LONG);
         check("long", 64'h3333_4444_1111_2222, v);
         {wr_from_secondary, wr_bus_secondary} = {1'b1, 64'h9};
         wreg(0, `DAG_CLS_L, 0, `DAG_FMT_NORMAL, 8'h05);
         wr_from_secondary = 1'b0;
         rdreg(0, `DAG_CLS_L, 0, `DAG_FMT_NORMAL); check("dual", 8'h05, v);
         simd_enable = 1'b1;
         rdreg(0, `DAG_CLS_M, 5, `DAG_FMT_NORMAL); check("bcast", 32'habcd_ef12, rd_bus_secondary);
         op(`DAG_OP_POST, 1, 1, 1, 0, 8'h04); check("addr", 8'h00, a_seen);
         op(`DAG_OP_POST, 1, 1, 1, 0, 8'h04); check("addr", 8'h04, a_seen);
         check("last", 8'h04, last_addr);
         check("accesses", 16'h9, accesses);
      end
   endtask
   task give_verdict;
      begin
         $display("mismatches %0d tests_run %0d", mismatches, tests_run);
         if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      {reset_n, circ_buf_enable, simd_enable, op_valid, op_unit, op_use_imm, op_wide} = 7'h0;
      {op_code, op_index, op_modify, wr_reg, rd_reg, op_imm} = 47'h0;
      {wr_valid, wr_unit, wr_from_secondary, rd_unit, wr_class, wr_fmt, rd_class, rd_fmt} = 12'h0;
      {wr_from_primary, wr_bus_primary, wr_bus_secondary} = {1'b1, 128'h0};
      {mismatches, tests_run} = 64'h0;
      repeat (16) @(posedge clk);
      #1;
      reset_n = 1'b1;
      circ_pos_wrap;
      circ_neg_imm;
      circ_off_modify;
      zero_len_bitrev;
      bus_formats;
      give_verdict;
   end
endmodule

// ==== verilog/dag_map.vh ====
// constants for the data address generator datapath
`ifndef DAG_MAP_VH
`define DAG_MAP_VH
`define DAG_WORD_W 32
`define DAG_BUS_W 64
`define DAG_REG_CNT 8
`define DAG_IDX_W 3
`define DAG_RST_VAL 32'h0000_0000
// register classes
`define DAG_CLS_I 2'h0
`define DAG_CLS_M 2'h1
`define DAG_CLS_L 2'h2
`define DAG_CLS_B 2'h3
// operations
`define DAG_OP_NONE 3'h0
`define DAG_OP_POST 3'h1
`define DAG_OP_PRE 3'h2
`define DAG_OP_MODIFY 3'h3
`define DAG_OP_BITREV 3'h4
// bus alignment formats
`define DAG_FMT_NORMAL 2'h0
`define DAG_FMT_EXT 2'h1
`define DAG_FMT_LONG 2'h2
`define DAG_EXT_LSB 8
`define DAG_HI_LSB 32
`endif

// ==== verilog/dag_regfile.v ====
// one register class of one generator unit, one registered read port plus an unregistered view of all entries
`timescale 1ns/1ps
`include "dag_map.vh"
module dag_regfile #(
   parameter WIDTH = 32,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk,
   input wire reset_n,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [WIDTH-1:0] wr_data,
   input wire wr2_en,
   input wire [AW-1:0] wr2_addr,
   input wire [WIDTH-1:0] wr2_data,
   input wire [AW-1:0] rd_addr,
   output reg [WIDTH-1:0] rd_data,
   output wire [WIDTH*DEPTH-1:0] all_data
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1)
      begin : g_ent
         assign all_data[g*WIDTH +: WIDTH] = mem_q[g];
         // second port wins: it carries the datapath update or the long-word upper half
         always @(posedge clk)
         begin
            if (!reset_n)
               mem_q[g] <= {WIDTH{1'b0}};
            else if (wr2_en && wr2_addr == g)
               mem_q[g] <= wr2_data;
            else if (wr_en && wr_addr == g)
               mem_q[g] <= wr_data;
         end
      end
   endgenerate
   always @(posedge clk)
   begin
      if (!reset_n)
         rd_data <= {WIDTH{1'b0}};
      else
         rd_data <= mem_q[rd_addr];
   end
endmodule

// ==== verilog/dag_unit.v ====
// data address generator: two units, circular buffers, bus alignment
//
// Contract
// - modify wraps whenever base and length set
// - post-modify emits index, then adds modifier
// - in-buffer sum written back unchanged
// - wrap subtracts or adds length at ends
// - modifier from any unit register or immediate
// - zero length disables wraparound
// - base write also loads index
// - index seven of each unit raises wrap interrupt
// - interrupt follows wrap comparison itself
// - straddling wide access completes before wrap; op_wide is unused, irq timing is the same
// - standalone modify, register or 32-bit immediate
// - bit-reverse modify with immediate, no memory
// - simd leaves addresses unchanged
// - simd broadcast to both element registers
// - primary element wins on dual source
// - register to register behaves as sisd
// - normal word on low bus bits
// - extended word on bits 39-8
// - even long word: next register upper half
// - odd long word: previous register upper half
// - circular disabled gives plain post-modify
// - pre-modify emits sum, no update, no wrap
`timescale 1ns/1ps
`include "dag_map.vh"
module dag_unit #(
   parameter W = 32,
   parameter BW = 64
) (
   input wire clk,
   input wire reset_n,
   input wire circ_buf_enable,
   input wire simd_enable,
   input wire op_valid,
   input wire [2:0] op_code,
   input wire op_unit,
   input wire [2:0] op_index,
   input wire op_use_imm,
   input wire [2:0] op_modify,
   input wire [W-1:0] op_imm,
   input wire op_wide,
   input wire wr_valid,
   input wire wr_unit,
   input wire [1:0] wr_class,
   input wire [2:0] wr_reg,
   input wire [1:0] wr_fmt,
   input wire wr_from_primary,
   input wire wr_from_secondary,
   input wire [BW-1:0] wr_bus_primary,
   input wire [BW-1:0] wr_bus_secondary,
   input wire rd_unit,
   input wire [1:0] rd_class,
   input wire [2:0] rd_reg,
   input wire [1:0] rd_fmt,
   output reg addr_valid,
   output reg addr_unit,
   output reg [W-1:0] addr_out,
   output reg [BW-1:0] rd_bus_primary,
   output reg [BW-1:0] rd_bus_secondary,
   output reg wrap_irq_index_unit_a,
   output reg wrap_irq_index_unit_b
);
   localparam IRQ_IDX = 3'h7;
   wire [W*8-1:0] all_i [0:1];
   wire [W*8-1:0] all_m [0:1];
   wire [W*8-1:0] all_l [0:1];
   wire [W*8-1:0] all_b [0:1];
   reg wrap_q [0:1];
   reg [W-1:0] idx_d;
   reg wrap_d;
   reg upd_en;
   reg [W-1:0] i_old;
   reg [W-1:0] m_val;
   reg [W-1:0] l_val;
   reg [W-1:0] b_val;
   reg [W:0] sum;
   reg [W:0] end_buf;
   reg [W-1:0] rev;
   reg [W-1:0] wval;
   reg [W-1:0] whi;
   reg circ_on;
   integer k;
   // primary element has precedence when both drive
   always @*
   begin
      wval = wr_bus_primary[W-1:0];
      whi = wr_bus_primary[BW-1:`DAG_HI_LSB];
      if (wr_from_primary || !wr_from_secondary)
      begin
         if (wr_fmt == `DAG_FMT_EXT)
            wval = wr_bus_primary[`DAG_EXT_LSB +: W];
         else
            wval = wr_bus_primary[W-1:0];
         whi = wr_bus_primary[BW-1:`DAG_HI_LSB];
      end
      else
      begin
         if (wr_fmt == `DAG_FMT_EXT)
            wval = wr_bus_secondary[`DAG_EXT_LSB +: W];
         else
            wval = wr_bus_secondary[W-1:0];
         whi = wr_bus_secondary[BW-1:`DAG_HI_LSB];
      end
   end
   // address datapath
   always @*
   begin
      i_old = all_i[op_unit][op_index*W +: W];
      m_val = op_use_imm ? op_imm : all_m[op_unit][op_modify*W +: W];
      l_val = all_l[op_unit][op_index*W +: W];
      b_val = all_b[op_unit][op_index*W +: W];
      sum = {1'b0, i_old} + {1'b0, m_val};
      end_buf = {1'b0, b_val} + {1'b0, l_val};
      idx_d = sum[W-1:0];
      wrap_d = 1'b0;
      upd_en = 1'b0;
      for (k = 0; k < W; k = k + 1)
         rev[k] = sum[W-1-k];
      circ_on = (l_val != {W{1'b0}});
      if (op_code == `DAG_OP_POST)
         circ_on = circ_on && circ_buf_enable;
      if (op_valid && (op_code == `DAG_OP_POST || op_code == `DAG_OP_MODIFY))
      begin
         upd_en = 1'b1;
         // wrap compare on signed modifier direction
         if (!m_val[W-1] && {1'b0, sum[W-1:0]} >= end_buf)
            wrap_d = 1'b1;
         else if (m_val[W-1] && sum[W-1:0] < b_val)
            wrap_d = 1'b1;
         if (circ_on && wrap_d)
            idx_d = m_val[W-1] ? sum[W-1:0] + l_val : sum[W-1:0] - l_val;
         // interrupt only when circ_buf_enable is set, whatever the length
         wrap_d = wrap_d && circ_buf_enable;
      end
      else if (op_valid && op_code == `DAG_OP_BITREV)
      begin
         upd_en = 1'b1;
         idx_d = rev;
      end
   end
   wire dp_wr [0:1];
   assign dp_wr[0] = upd_en && !op_unit;
   assign dp_wr[1] = upd_en && op_unit;
   wire [W-1:0] rd_i [0:1];
   wire [W-1:0] rd_m [0:1];
   wire [W-1:0] rd_l [0:1];
   wire [W-1:0] rd_b [0:1];
   genvar u;
   generate
      for (u = 0; u < 2; u = u + 1)
      begin : g_unit
         wire wsel = wr_valid && (wr_unit == u);
         wire lw = (wr_fmt == `DAG_FMT_LONG);
         wire [2:0] pair = wr_reg ^ 3'h1;
         // base load copies into index
         wire i_wr = wsel && (wr_class == `DAG_CLS_I || wr_class == `DAG_CLS_B);
         wire i_wr2 = (wsel && lw && (wr_class == `DAG_CLS_I || wr_class == `DAG_CLS_B));
         dag_regfile #(.WIDTH(W), .DEPTH(8), .AW(3)) u_i (
            .clk(clk), .reset_n(reset_n),
            .wr_en(i_wr && !(dp_wr[u] && op_index == wr_reg)),
            .wr_addr(wr_reg), .wr_data(wval),
            .wr2_en(dp_wr[u] || i_wr2),
            .wr2_addr(dp_wr[u] ? op_index : pair),
            .wr2_data(dp_wr[u] ? idx_d : whi),
            .rd_addr(rd_reg), .rd_data(rd_i[u]), .all_data(all_i[u]));
         dag_regfile #(.WIDTH(W), .DEPTH(8), .AW(3)) u_m (
            .clk(clk), .reset_n(reset_n),
            .wr_en(wsel && wr_class == `DAG_CLS_M), .wr_addr(wr_reg), .wr_data(wval),
            .wr2_en(wsel && lw && wr_class == `DAG_CLS_M), .wr2_addr(pair),
            .wr2_data(whi), .rd_addr(rd_reg), .rd_data(rd_m[u]), .all_data(all_m[u]));
         dag_regfile #(.WIDTH(W), .DEPTH(8), .AW(3)) u_l (
            .clk(clk), .reset_n(reset_n),
            .wr_en(wsel && wr_class == `DAG_CLS_L), .wr_addr(wr_reg), .wr_data(wval),
            .wr2_en(wsel && lw && wr_class == `DAG_CLS_L), .wr2_addr(pair),
            .wr2_data(whi), .rd_addr(rd_reg), .rd_data(rd_l[u]), .all_data(all_l[u]));
         dag_regfile #(.WIDTH(W), .DEPTH(8), .AW(3)) u_b (
            .clk(clk), .reset_n(reset_n),
            .wr_en(wsel && wr_class == `DAG_CLS_B), .wr_addr(wr_reg), .wr_data(wval),
            .wr2_en(wsel && lw && wr_class == `DAG_CLS_B), .wr2_addr(pair),
            .wr2_data(whi), .rd_addr(rd_reg), .rd_data(rd_b[u]), .all_data(all_b[u]));
         // wrap flag registered here, irq outputs one cycle later; op_wide plays no part
         always @(posedge clk)
         begin
            if (!reset_n)
               wrap_q[u] <= 1'b0;
            else
               wrap_q[u] <= dp_wr[u] && wrap_d && op_index == IRQ_IDX && op_code != `DAG_OP_BITREV;
         end
      end
   endgenerate
   // read side, one cycle after request
   reg rd_unit_q;
   reg [1:0] rd_class_q;
   reg [1:0] rd_fmt_q;
   reg [W-1:0] rd_lo;
   reg [W-1:0] rd_pair;
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         rd_unit_q <= 1'b0;
         rd_class_q <= `DAG_CLS_I;
         rd_fmt_q <= `DAG_FMT_NORMAL;
         rd_pair <= {W{1'b0}};
      end
      else
      begin
         rd_unit_q <= rd_unit;
         rd_class_q <= rd_class;
         rd_fmt_q <= rd_fmt;
         case (rd_class)
            `DAG_CLS_I: rd_pair <= all_i[rd_unit][(rd_reg ^ 3'h1)*W +: W];
            `DAG_CLS_M: rd_pair <= all_m[rd_unit][(rd_reg ^ 3'h1)*W +: W];
            `DAG_CLS_L: rd_pair <= all_l[rd_unit][(rd_reg ^ 3'h1)*W +: W];
            default: rd_pair <= all_b[rd_unit][(rd_reg ^ 3'h1)*W +: W];
         endcase
      end
   end
   always @*
   begin
      case (rd_class_q)
         `DAG_CLS_I: rd_lo = rd_i[rd_unit_q];
         `DAG_CLS_M: rd_lo = rd_m[rd_unit_q];
         `DAG_CLS_L: rd_lo = rd_l[rd_unit_q];
         default: rd_lo = rd_b[rd_unit_q];
      endcase
   end
   reg [BW-1:0] bus_d;
   always @*
   begin
      case (rd_fmt_q)
         `DAG_FMT_EXT: bus_d = {{(BW-W-`DAG_EXT_LSB){1'b0}}, rd_lo, 8'h00};
         `DAG_FMT_LONG: bus_d = {rd_pair, rd_lo};
         default: bus_d = {{(BW-W){1'b0}}, rd_lo};
      endcase
   end
   // bus outputs registered a second cycle for flop-driven data
   always @(posedge clk)
   begin
      if (!reset_n)
      begin
         rd_bus_primary <= {BW{1'b0}};
         rd_bus_secondary <= {BW{1'b0}};
         addr_valid <= 1'b0;
         addr_unit <= 1'b0;
         addr_out <= {W{1'b0}};
         wrap_irq_index_unit_a <= 1'b0;
         wrap_irq_index_unit_b <= 1'b0;
      end
      else
      begin
         rd_bus_primary <= bus_d;
         rd_bus_secondary <= simd_enable ? bus_d : {BW{1'b0}};
         // addresses do not depend on simd_enable
         addr_valid <= op_valid && (op_code == `DAG_OP_POST || op_code == `DAG_OP_PRE);
         addr_unit <= op_unit;
         addr_out <= (op_code == `DAG_OP_PRE) ? sum[W-1:0] : i_old;
         wrap_irq_index_unit_a <= wrap_q[0];
         wrap_irq_index_unit_b <= wrap_q[1];
      end
   end
   // are software duties; no hardware check
   wire unused_ok = op_wide;
endmodule
